// *** rtl/acdma_engine.sv ***
// Purpose: One playback bus master with descriptor walking and codec register access.
// Assumes: Memory reads hold mem_req until a one-cycle mem_ack with mem_rdata.
// Notes: Link-side strobes come from logic on mclk and are not synchronised.
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
module acdma_engine #(
	parameter bit STEREO = 1'b1
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic [4:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest,
	output logic                         mem_req,
	output logic [31:0]                  mem_addr,
	input  wire logic                    mem_ack,
	input  wire logic [31:0]             mem_rdata,
	input  wire logic                    sample_req,
	output acdma_pkg::acdma_sample_type  sample_out,
	output logic                         slot_valid,
	output acdma_pkg::acdma_ccmd_type    codec_cmd,
	output logic                         codec_cmd_new,
	input  wire logic                    codec_cmd_taken,
	input  wire logic                    codec_stat_valid,
	input  wire acdma_pkg::acdma_cstat_type codec_stat,
	output logic                         irq
);
	import acdma_pkg::*;

	localparam logic [15:0] STEP = STEREO ? 16'h0004 : 16'h0002;

	acdma_state_type  st_q;
	logic             en_q, pause_q, bigend_q, eop_q, err_q, pend_q;
	logic             d_eop_q, d_eot_q, half_q, cs_new_q, wr_q;
	logic [31:0]      table_q, buf_q, word_q, rdata_q;
	logic [15:0]      remain_q;
	acdma_cstat_type  cs_q;
	acdma_sample_type unpacked;
	logic             accept, wr_acc, rd_acc, rd_irq, rd_cs, desc1_ack;
	logic             eop_set, err_set, eot_stop, jump_now;
	logic             eop_clr, err_clr, cs_clr;
	logic [31:0]      wval, cur;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// One wait state: the answer edge is the one where waitrequest is sampled low.
	assign avs_waitrequest = wr_q;
	assign accept  = (avs_read || avs_write) && !wr_q;
	assign wr_acc  = accept && avs_write;
	assign rd_acc  = accept && avs_read;
	assign rd_irq  = rd_acc && (avs_address == OFS_IRQ);
	assign rd_cs   = rd_acc && (avs_address == OFS_CSTAT);

	always_comb begin
		unique case (avs_address)
			OFS_CMD:   cur = {29'h0, bigend_q, pause_q, en_q};
			OFS_IRQ:   cur = {30'h0, err_q, eop_q};
			OFS_TABLE: cur = table_q;
			OFS_CCTL:  cur = {7'h0, codec_cmd_new, codec_cmd};
			OFS_CSTAT: cur = {7'h0, cs_new_q, 1'b0, cs_q};
			OFS_IRQ2:  cur = {31'h0, eop_q || err_q};
			default:   cur = 32'h0000_0000;
		endcase
		wval = merge(cur, avs_writedata, avs_byteenable);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_q    <= 1'b1;
			rdata_q <= RST_WORD;
		end else begin
			wr_q <= !((avs_read || avs_write) && wr_q);
			if (avs_read && wr_q) begin
				rdata_q <= cur;
			end
		end
	end
	assign avs_readdata = rdata_q;

	assign desc1_ack = (st_q == ST_DESC1) && mem_req && mem_ack;
	assign jump_now  = mem_rdata[DESC_JMP_BIT];
	// A paused master keeps pend_q and a disabled one clears it, so completions count only while running.
	assign eop_set   = en_q && !pause_q && (st_q == ST_NEXT) && pend_q && !eop_q;
	assign err_set   = en_q && !pause_q && (st_q == ST_NEXT) && pend_q && eop_q && !err_q;
	assign eot_stop  = en_q && (st_q == ST_NEXT) && !pend_q && !err_q && d_eot_q && !pause_q;
	assign eop_clr   = rd_irq && rdata_q[IRQ_EOP_BIT];
	assign err_clr   = rd_irq && rdata_q[IRQ_ERR_BIT];
	assign cs_clr    = rd_cs && rdata_q[CS_NEW_BIT];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en_q     <= 1'b0;
			pause_q  <= 1'b0;
			bigend_q <= 1'b0;
		end else begin
			if (wr_acc && avs_address == OFS_CMD) begin
				en_q     <= wval[CMD_EN_BIT];
				pause_q  <= wval[CMD_PAUSE_BIT];
				bigend_q <= wval[CMD_BIGEND_BIT];
			end
			if (eot_stop) begin
				en_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			table_q <= RST_TABLE;
		end else if (desc1_ack) begin
			table_q <= jump_now ? buf_q : table_q + DESC_STRIDE;
		end else if (wr_acc && avs_address == OFS_TABLE) begin
			table_q <= wval;
		end
	end

	// Flags set by the engine win over a clear by a status read in the same cycle.
	// A read clears only the flags it returned, so an event that lands between the
	// capture of read data and the clear is not lost.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			eop_q <= 1'b0;
			err_q <= 1'b0;
			irq   <= 1'b0;
		end else begin
			eop_q <= eop_set || (eop_q && !eop_clr);
			err_q <= err_set || (err_q && !err_clr);
			irq   <= eop_set || err_set || (eop_q && !eop_clr) || (err_q && !err_clr);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			codec_cmd     <= '0;
			codec_cmd_new <= 1'b0;
		end else begin
			if (wr_acc && avs_address == OFS_CCTL) begin
				codec_cmd.data <= wval[15:0];
				codec_cmd.addr <= wval[CC_ADDR_LSB +: 7];
				codec_cmd.rd   <= wval[CC_RW_BIT];
			end
			if (wr_acc && avs_address == OFS_CCTL && wval[CC_NEW_BIT]) begin
				codec_cmd_new <= 1'b1;
			end else if (codec_cmd_taken) begin
				codec_cmd_new <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cs_q     <= '0;
			cs_new_q <= 1'b0;
		end else begin
			if (codec_stat_valid) begin
				cs_q <= codec_stat;
			end
			cs_new_q <= codec_stat_valid || (cs_new_q && !cs_clr);
		end
	end

	// An outstanding memory read is always completed, even when paused or disabled,
	// so that no acknowledge is ever left unclaimed.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q     <= ST_IDLE;
			mem_req  <= 1'b0;
			mem_addr <= RST_WORD;
			buf_q    <= RST_WORD;
			word_q   <= RST_WORD;
			remain_q <= 16'h0000;
			d_eop_q  <= 1'b0;
			d_eot_q  <= 1'b0;
			pend_q   <= 1'b0;
			half_q   <= 1'b0;
		end else begin
			if (mem_req && mem_ack) begin
				mem_req <= 1'b0;
			end
			if (!en_q) begin
				if (!mem_req || mem_ack) begin
					st_q   <= ST_IDLE;
					pend_q <= 1'b0;
				end
			end else if (!pause_q || mem_req) begin
				unique case (st_q)
					ST_IDLE: begin
						st_q <= ST_DESC0;
					end
					ST_DESC0: begin
						if (!mem_req) begin
							mem_req  <= 1'b1;
							mem_addr <= table_q;
						end else if (mem_ack) begin
							buf_q <= mem_rdata;
							st_q  <= ST_DESC1;
						end
					end
					ST_DESC1: begin
						if (!mem_req) begin
							mem_req  <= 1'b1;
							mem_addr <= table_q + DESC_WORD1;
						end else if (mem_ack) begin
							d_eop_q  <= mem_rdata[DESC_EOP_BIT];
							d_eot_q  <= mem_rdata[DESC_EOT_BIT];
							remain_q <= mem_rdata[15:0];
							half_q   <= 1'b0;
							if (jump_now) begin
								st_q <= ST_DESC0;
							end else if (mem_rdata[15:0] == 16'h0000) begin
								st_q <= ST_NEXT;
							end else begin
								st_q <= ST_WORD;
							end
						end
					end
					ST_WORD: begin
						if (!mem_req) begin
							mem_req  <= 1'b1;
							mem_addr <= buf_q;
						end else if (mem_ack) begin
							word_q <= mem_rdata;
							buf_q  <= buf_q + WORD_BYTES;
							st_q   <= ST_PLAY;
						end
					end
					ST_PLAY: begin
						if (sample_req) begin
							remain_q <= remain_q - STEP;
							if (remain_q <= STEP) begin
								pend_q <= d_eop_q;
								st_q   <= ST_NEXT;
							end else if (STEREO || half_q) begin
								half_q <= 1'b0;
								st_q   <= ST_WORD;
							end else begin
								half_q <= 1'b1;
							end
						end
					end
					ST_NEXT: begin
						if (pend_q) begin
							pend_q <= 1'b0;
						end else if (!err_q) begin
							st_q <= d_eot_q ? ST_IDLE : ST_DESC0;
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	acdma_unpack #(
		.STEREO     (STEREO)
	) u_unpack (
		.big_endian (bigend_q),
		.half_sel   (half_q),
		.word       (word_q),
		.sample     (unpacked)
	);

	// Slots stay invalid from an underrun or pause until a sample is really held.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sample_out <= '0;
			slot_valid <= 1'b0;
		end else if (sample_req) begin
			slot_valid <= en_q && !pause_q && (st_q == ST_PLAY);
			sample_out <= unpacked;
		end
	end

	chk_table_advance: assert property (@(posedge mclk) disable iff (rst)
		desc1_ack && !jump_now |=> table_q == $past(table_q) + DESC_STRIDE)
		else $error("table address did not advance by eight");

	chk_jump_target: assert property (@(posedge mclk) disable iff (rst)
		desc1_ack && jump_now |=> table_q == $past(buf_q) && st_q == ST_DESC0
		&& eop_q == $past(eop_q))
		else $error("jump descriptor not followed");

	chk_eot_clears_en: assert property (@(posedge mclk) disable iff (rst)
		eot_stop && !wr_acc |=> !en_q ##1 st_q == ST_IDLE)
		else $error("end of table did not stop the master");

	chk_status_read_clears: assert property (@(posedge mclk) disable iff (rst)
		rd_irq && !eop_set && !err_set |=> !(eop_q && $past(eop_clr))
		&& !(err_q && $past(err_clr)) && irq == (eop_q || err_q))
		else $error("status read left a flag set");

	chk_pause_freezes: assert property (@(posedge mclk) disable iff (rst)
		pause_q && en_q && st_q == ST_PLAY && !wr_acc |=> $stable(st_q) && $stable(remain_q))
		else $error("paused master moved");

	chk_second_page_err: assert property (@(posedge mclk) disable iff (rst)
		err_set |=> err_q && st_q == ST_NEXT ##1 (st_q == ST_NEXT || !en_q || rd_irq))
		else $error("second page completion did not halt with error");

	chk_page_flag_set: assert property (@(posedge mclk) disable iff (rst)
		eop_set |=> eop_q && irq)
		else $error("page completion did not raise flag and interrupt");

	chk_cmd_taken: assert property (@(posedge mclk) disable iff (rst)
		codec_cmd_taken && !wr_acc |=> !codec_cmd_new)
		else $error("command-new not cleared after command sent");

	chk_status_new: assert property (@(posedge mclk) disable iff (rst)
		codec_stat_valid |=> cs_new_q && cs_q == $past(codec_stat))
		else $error("status-new not set with read data");

	chk_underrun_invalid: assert property (@(posedge mclk) disable iff (rst)
		sample_req && st_q != ST_PLAY |=> !slot_valid)
		else $error("slot marked valid during underrun");

endmodule : acdma_engine

// *** rtl/acdma_pkg.sv ***
// Purpose: Shared constants and types for the audio descriptor DMA and codec access block.
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one 125 MHz clock.
// Notes: Descriptor words and registers are little-endian; only PCM samples may be swapped.
package acdma_pkg;

	localparam logic [4:0] OFS_CMD    = 5'h00;
	localparam logic [4:0] OFS_IRQ    = 5'h04;
	localparam logic [4:0] OFS_TABLE  = 5'h08;
	localparam logic [4:0] OFS_CCTL   = 5'h0C;
	localparam logic [4:0] OFS_CSTAT  = 5'h10;
	localparam logic [4:0] OFS_IRQ2   = 5'h14;

	localparam int CMD_EN_BIT     = 0;
	localparam int CMD_PAUSE_BIT  = 1;
	localparam int CMD_BIGEND_BIT = 2;
	localparam int IRQ_EOP_BIT    = 0;
	localparam int IRQ_ERR_BIT    = 1;
	localparam int CC_ADDR_LSB    = 16;
	localparam int CC_RW_BIT      = 23;
	localparam int CC_NEW_BIT     = 24;
	localparam int CS_NEW_BIT     = 24;

	localparam int DESC_EOP_BIT   = 31;
	localparam int DESC_EOT_BIT   = 30;
	localparam int DESC_JMP_BIT   = 29;
	localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
	localparam logic [31:0] DESC_WORD1  = 32'h0000_0004;
	localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;

	localparam logic [31:0] RST_TABLE = 32'h0000_0000;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_DESC0 = 3'h1,
		ST_DESC1 = 3'h3,
		ST_WORD  = 3'h2,
		ST_PLAY  = 3'h6,
		ST_NEXT  = 3'h7
	} acdma_state_type;

	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
	} acdma_sample_type;

	typedef struct packed {
		logic        rd;
		logic [6:0]  addr;
		logic [15:0] data;
	} acdma_ccmd_type;

	typedef struct packed {
		logic [6:0]  addr;
		logic [15:0] data;
	} acdma_cstat_type;

endpackage : acdma_pkg

// *** rtl/acdma_unpack.sv ***
// Purpose: Turns one fetched memory word into a PCM sample pair.
// Assumes: Memory word is little-endian by byte lane, lowest address in bits 7:0.
// Notes: Purely combinational; the engine registers the result.
`timescale 1ns/1ps
module acdma_unpack #(
	parameter bit STEREO = 1'b1
) (
	input  wire logic                       big_endian,
	input  wire logic                       half_sel,
	input  wire logic [31:0]                word,
	output acdma_pkg::acdma_sample_type     sample
);
	import acdma_pkg::*;

	logic [15:0] lo_half;
	logic [15:0] hi_half;

	// Lower address byte is the low byte unless big endian is chosen.
	always_comb begin
		lo_half = big_endian ? {word[7:0], word[15:8]} : word[15:0];
		hi_half = big_endian ? {word[23:16], word[31:24]} : word[31:16];
		if (STEREO) begin
			sample.left  = lo_half;
			sample.right = hi_half;
		end else begin
			sample.left  = half_sel ? hi_half : lo_half;
			sample.right = sample.left;
		end
	end

endmodule : acdma_unpack

// *** test/acdma_link_model.sv ***
// Purpose: Far-side model of the engine: system memory and codec link logic.
// Assumes: One clock shared with the engine; memory holds 128 words.
// Notes: Idle data lines (mem_rdata, codec_stat) show the inverse of their last value, so stale data cannot pass.
`timescale 1ns/1ps
module acdma_link_model (
	input  wire logic                      mclk,
	input  wire logic                      run,
	input  wire logic                      mem_req,
	input  wire logic [31:0]               mem_addr,
	output logic                           mem_ack,
	output logic [31:0]                    mem_rdata,
	output logic                           sample_req,
	input  wire acdma_pkg::acdma_ccmd_type codec_cmd,
	input  wire logic                      codec_cmd_new,
	output logic                           codec_cmd_taken,
	output logic                           codec_stat_valid,
	output acdma_pkg::acdma_cstat_type     codec_stat
);
	import acdma_pkg::*;
	logic [31:0] mem [0:127];
	logic [7:0]  cnt_q   = 8'h00;
	logic [7:0]  mwait_q = 8'h00;
	logic [7:0]  cwait_q = 8'h00;
	// The read flag is latched when a command is taken, so a command queued while an
	// earlier write is still on the link cannot produce a status before it is sent.
	logic        cmd_rd_q = 1'b0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		sample_req = 1'b0;
		codec_cmd_taken = 1'b0;
		codec_stat_valid = 1'b0;
		codec_stat = '0;
	end
	// Memory latency swaps between prompt and slow every 64 cycles.
	always @(posedge mclk) begin
		cnt_q <= cnt_q + 8'h01;
		sample_req <= run && cnt_q[1:0] == 2'h0;
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && mwait_q >= {5'h00, cnt_q[6], 2'h0}) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr[8:2]];
			mwait_q <= 8'h00;
		end else if (mem_req && !mem_ack)
			mwait_q <= mwait_q + 8'h01;
	end
	always @(posedge mclk) begin
		codec_cmd_taken <= cwait_q == 8'h06;
		if (cwait_q == 8'h06)
			cmd_rd_q <= codec_cmd.rd;
		codec_stat_valid <= cwait_q == 8'h1E && cmd_rd_q;
		codec_stat <= ~codec_stat;
		if (cwait_q == 8'h1E)
			codec_stat <= {codec_cmd.addr, codec_cmd.addr, 9'h0A5};
		if (cwait_q != 8'h00 || codec_cmd_new)
			cwait_q <= cwait_q == 8'h1F ? 8'h00 : cwait_q + 8'h01;
	end
endmodule : acdma_link_model

// *** test/audio_descriptor_dma_and_codec_access_tb_top.sv ***
// Purpose: Self-checking bench for the stereo audio descriptor DMA engine.
// Assumes: Memory and codec link come from acdma_link_model.
// Notes: Valid samples are queued as they leave and compared with memory contents.
`timescale 1ns/1ps
module audio_descriptor_dma_and_codec_access_tb_top;
	import acdma_pkg::*;
	localparam logic [31:0] F_EOP = 32'h1 << DESC_EOP_BIT;
	localparam logic [31:0] F_EOT = 32'h1 << DESC_EOT_BIT;
	localparam logic [31:0] F_JMP = 32'h1 << DESC_JMP_BIT;
	logic             mclk = 1'b0;
	logic             rst = 1'b1;
	logic             run = 1'b0;
	logic [4:0]       avs_address = 5'h00;
	logic             avs_read = 1'b0;
	logic             avs_write = 1'b0;
	logic [31:0]      avs_writedata = 32'h0;
	logic [31:0]      avs_readdata, mem_addr, mem_rdata, q;
	logic             avs_waitrequest, mem_req, mem_ack, sample_req, slot_valid, irq;
	logic             codec_cmd_new, codec_cmd_taken, codec_stat_valid;
	logic             sreq_d = 1'b0;
	acdma_sample_type sample_out;
	acdma_ccmd_type   codec_cmd;
	acdma_cstat_type  codec_stat;
	acdma_sample_type got[$];
	int               err_count = 0;
	int               check_count = 0;
	int               inv_cnt = 0;
	int               k;
	integer           seed = 32'h0375;
	logic [6:0]       a7;
	logic [15:0]      d16;

	acdma_engine #(.STEREO(1'b1)) dut_u (.mclk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .mem_req,
		.mem_addr, .mem_ack, .mem_rdata, .sample_req, .sample_out, .slot_valid, .codec_cmd,
		.codec_cmd_new, .codec_cmd_taken, .codec_stat_valid, .codec_stat, .irq);
	acdma_link_model link_u (.mclk, .run, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
		.sample_req, .codec_cmd, .codec_cmd_new, .codec_cmd_taken, .codec_stat_valid,
		.codec_stat);

	always #4 mclk = ~mclk;

	// A sample is settled one edge after its request, so the request is delayed here.
	always @(posedge mclk) begin
		if (sreq_d && slot_valid === 1'b1)
			got.push_back(sample_out);
		if (sreq_d && slot_valid === 1'b0)
			inv_cnt++;
		sreq_d <= sample_req;
	end

	task automatic print_verdict;
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	task automatic give_up;
		err_count++;
		print_verdict();
	endtask : give_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// The extra edge at the end keeps two requests from being driven in one time step.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] v);
		int n;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		v = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 50)
			give_up();
		@(posedge mclk);
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] v);
		bus(1'b0, a, 32'h0, v);
	endtask : rd

	task automatic poll(input logic [4:0] a, input int b, input logic v);
		int n;
		for (n = 0; n < 500; n++) begin
			rd(a, q);
			if (q[b] === v)
				break;
		end
		if (n == 500)
			give_up();
	endtask : poll

	task automatic wait_got(input int n);
		int c;
		for (c = 0; c < 3000 && got.size() < n; c++)
			@(posedge mclk);
		if (c == 3000)
			give_up();
	endtask : wait_got

	task automatic desc(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		link_u.mem[a[8:2]] = b;
		link_u.mem[a[8:2] + 7'h01] = c;
	endtask : desc

	task automatic start(input logic [31:0] t, input logic [31:0] c);
		wr(OFS_TABLE, t);
		rd(OFS_IRQ, q);
		wr(OFS_CMD, c);
		run <= 1'b1;
	endtask : start

	function automatic acdma_sample_type exp_s(input logic [31:0] w, input logic be);
		exp_s.left = be ? {w[7:0], w[15:8]} : w[15:0];
		exp_s.right = be ? {w[23:16], w[31:24]} : w[31:16];
	endfunction : exp_s

	task automatic cmp_got(input logic [31:0] a, input int n, input logic be);
		for (int i = 0; i < n; i++)
			check(got[i], exp_s(link_u.mem[a[8:2] + 7'(i)], be), "sample");
		got.delete();
	endtask : cmp_got

	initial begin
		for (k = 0; k < 128; k++)
			link_u.mem[k] = $random(seed);
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (k = 0; k < 7; k++) begin
			rd(5'(k * 4), q);
			check(q, 32'h0, "reset value");
		end
		desc(32'h00, 32'h100, F_EOP | 32'h8);
		desc(32'h08, 32'h108, F_EOT | 32'h4);
		start(32'h00, 32'h1);
		wait_got(3);
		poll(OFS_CMD, CMD_EN_BIT, 1'b0);
		cmp_got(32'h100, 3, 1'b0);
		check(irq, 1'b1, "irq");
		rd(OFS_IRQ2, q);
		check(q, 32'h1, "second level status");
		rd(OFS_TABLE, q);
		check(q, 32'h10, "table address");
		rd(OFS_IRQ, q);
		check(q, 32'h1, "irq status");
		rd(OFS_IRQ, q);
		check(q, 32'h0, "irq status");
		@(posedge mclk);
		check(irq, 1'b0, "irq");
		desc(32'h20, 32'h30, F_JMP);
		desc(32'h30, 32'h110, F_EOT | 32'h10);
		start(32'h20, 32'h5);
		wait_got(1);
		wr(OFS_CMD, 32'h7);
		// A sample granted at the pause edge is queued one edge later.
		@(posedge mclk);
		k = got.size();
		q = inv_cnt;
		repeat (40) @(posedge mclk);
		check(got.size(), k, "paused count");
		check(inv_cnt > q, 1'b1, "paused slots invalid");
		wr(OFS_CMD, 32'h5);
		wait_got(4);
		poll(OFS_CMD, CMD_EN_BIT, 1'b0);
		cmp_got(32'h110, 4, 1'b1);
		check(irq, 1'b0, "irq");
		rd(OFS_TABLE, q);
		check(q, 32'h38, "table address");
		desc(32'h40, 32'h120, F_EOP | 32'h4);
		desc(32'h48, 32'h124, F_EOP | 32'h4);
		desc(32'h50, 32'h128, F_EOT | 32'h4);
		start(32'h40, 32'h1);
		wait_got(1);
		repeat (80) @(posedge mclk);
		check(got.size() < 3, 1'b1, "halted on error");
		check(irq, 1'b1, "irq");
		rd(OFS_IRQ, q);
		check(q, 32'h3, "irq status");
		wait_got(3);
		poll(OFS_CMD, CMD_EN_BIT, 1'b0);
		cmp_got(32'h120, 3, 1'b0);
		rd(OFS_IRQ, q);
		check(q, 32'h0, "irq status");
		desc(32'h60, 32'h130, 32'h10);
		desc(32'h68, 32'h140, F_EOT | 32'h4);
		link_u.mem[7'h50] = {2{link_u.mem[7'h50][15:0]}};
		start(32'h60, 32'h1);
		wait_got(1);
		run <= 1'b0;
		wr(OFS_CMD, 32'h0);
		rd(OFS_TABLE, q);
		check(q, 32'h68, "table address");
		cmp_got(32'h130, 1, 1'b0);
		wr(OFS_CMD, 32'h1);
		run <= 1'b1;
		wait_got(1);
		cmp_got(32'h140, 1, 1'b0);
		poll(OFS_CMD, CMD_EN_BIT, 1'b0);
		for (k = 0; k < 3; k++) begin
			a7 = $random(seed);
			d16 = $random(seed);
			wr(OFS_CCTL, {7'h00, 2'h3, a7, d16});
			check(codec_cmd, {1'b1, a7, d16}, "codec read command");
			poll(OFS_CCTL, CC_NEW_BIT, 1'b0);
			rd(OFS_CSTAT, q);
			check(q[CS_NEW_BIT], 1'b0, "status new early");
			poll(OFS_CSTAT, CS_NEW_BIT, 1'b1);
			check(q & 32'h017F_FFFF, {7'h00, 2'h2, a7, a7, 9'h0A5}, "codec status");
			wr(OFS_CCTL, {7'h00, 2'h2, a7, d16});
			check(codec_cmd, {1'b0, a7, d16}, "codec write command");
			poll(OFS_CCTL, CC_NEW_BIT, 1'b0);
		end
		print_verdict();
	end
endmodule : audio_descriptor_dma_and_codec_access_tb_top
